// [design/crd_code_fifo.sv]
// crd_code_fifo: code FIFO between the memory fetch and the guest writer.
// assumes: one clock, async active-high reset, valid/ready on both sides.
`timescale 1ns/1ps
module crd_code_fifo
  import crd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [CRD_FIFO_W-1:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [CRD_FIFO_W-1:0] rdData
);

  logic [CRD_FIFO_W-1:0] mem [CRD_FIFO_D];   // storage words
  logic [2:0] wrPtr_ff;                      // write index
  logic [2:0] rdPtr_ff;                      // read index
  logic [3:0] count_ff;                      // words held
  wire push = wrValid && wrReady;            // accepted write
  wire pop = rdValid && rdReady;             // accepted read

  assign wrReady = (count_ff != 4'(CRD_FIFO_D));
  assign rdValid = (count_ff != 4'h0);
  assign rdData = mem[rdPtr_ff];

  // storage write, no reset needed
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wrPtr_ff] <= wrData;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wrPtr_ff <= 3'h0;
      rdPtr_ff <= 3'h0;
      count_ff <= 4'h0;
    end
    else
    begin
      wrPtr_ff <= wrPtr_ff + 3'(push);
      rdPtr_ff <= rdPtr_ff + 3'(pop);
      count_ff <= count_ff + 4'(push) - 4'(pop);
    end
  end

  // level never passes depth, and a lone push adds exactly one word
  property p_fifo_level;
    @(posedge ref_clk) disable iff (sys_rst)
    push && !pop |=> count_ff == $past(count_ff) + 4'h1;
  endproperty
  a_fifo_level: assert property (p_fifo_level)
    else $error("fifo level did not follow push");

  property p_fifo_bound;
    @(posedge ref_clk) disable iff (sys_rst)
    count_ff <= 4'(CRD_FIFO_D);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo overfilled");

endmodule

// [design/crd_code_read_dma.sv]
// crd_code_read_dma: cyclic code-buffer fetch, code FIFO and guest port
// writer, with GPIO pins and an interrupt, behind an Avalon-MM slave.
// assumes: memory side is an Avalon-MM read master port with waitrequest;
// guest port and GPIO pins are outside the clock domain.
//
// What this block does
// - GPIO pins are inputs after reset
// - output pins follow their value register bit
// - code writes go to guest id 0..3
// - strobe duration/recovery held at offset 0x030
// - each guest has eight 8-bit locations
// - new fetches start only while code-read enable is one
// - fetch address wraps cyclically to buffer base
// - interrupt at each report-step boundary crossing
// - current fetch pointer is readable
// - code goes through FIFO to guest target
`timescale 1ns/1ps
module crd_code_read_dma
  import crd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [31:0] memAddress,
  output logic memRead,
  input wire logic [31:0] memReaddata,
  input wire logic memWaitrequest,
  output logic [3:0] gCsN,
  output logic [2:0] gAdr,
  output logic [7:0] gDatOut,
  output logic gDatOeN,
  output logic gWrN,
  input wire logic [7:0] gpioIn,
  output logic [7:0] gpioOut,
  output logic [7:0] gpioOeN,
  output logic irq
);

  // all-ones mask of the low lg bits of a buffer offset
  function automatic logic [CRD_OFS_W-1:0] crdMask(input logic [4:0] lg);
    crdMask = CRD_OFS_W'((32'h1 << lg) - 32'h1);
  endfunction

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] crdMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    crdMerge = res;
  endfunction

  // register state
  logic avsWaitrequest_ff;         // slave wait, high when idle
  logic [31:0] avsReaddata_ff;     // read answer
  logic [7:0] gpioDir_ff;          // pin direction, 1 = output
  logic [7:0] gpioVal_ff;          // pin output values
  logic [10:0] ctrl_ff;            // enable, guest, size, step
  logic [31:0] base_ff;            // buffer base, word aligned
  logic [3:0] tdur_ff;             // strobe low cycles
  logic [3:0] trec_ff;             // strobe high cycles
  logic [1:0] sts_ff;              // sticky events
  logic [1:0] mask_ff;             // event mask
  logic irq_ff;                    // interrupt output
  logic [7:0] gpioSync1_ff;        // pin synchroniser stage 1
  logic [7:0] gpioSync2_ff;        // pin synchroniser stage 2
  logic [7:0] gpioOut_ff;          // pin drive values
  logic [7:0] gpioOeN_ff;          // pin enables, low drives
  logic [CRD_OFS_W-1:0] offset_ff; // fetch offset in buffer
  logic memRead_ff;                // memory read request
  logic [31:0] memAddress_ff;      // memory read address

  // bus decode
  wire avsReq = avsRead || avsWrite;
  wire avsTake = avsReq && avsWaitrequest_ff;   // load read answer
  wire avsDone = avsReq && !avsWaitrequest_ff;  // request completes
  wire wrDone = avsWrite && !avsWaitrequest_ff;
  wire [31:0] wrMerged = crdMerge(32'h0, avsWritedata, avsByteenable);
  wire wrDir = wrDone && avsAddress == CRD_OFS_GPIO_DIR;
  wire wrVal = wrDone && avsAddress == CRD_OFS_GPIO_VAL;
  wire wrCtrl = wrDone && avsAddress == CRD_OFS_CTRL;
  wire wrBase = wrDone && avsAddress == CRD_OFS_BASE;
  wire wrSts = wrDone && avsAddress == CRD_OFS_STS;
  wire wrMask = wrDone && avsAddress == CRD_OFS_MASK;
  wire wrGtim = wrDone && avsAddress == CRD_OFS_GTIM;
  wire [31:0] ctrlNew = crdMerge(32'(ctrl_ff), avsWritedata, avsByteenable);
  wire [31:0] gtimNew = crdMerge({20'h0, trec_ff, 4'h0, tdur_ff},
                                 avsWritedata, avsByteenable);

  // fields of the control register
  wire codeEn = ctrl_ff[CRD_CTRL_EN];
  wire [1:0] guestId = ctrl_ff[CRD_CTRL_GID +: 2];
  wire [2:0] sizeSel = ctrl_ff[CRD_CTRL_SIZE +: 3];
  wire [2:0] stepSel = ctrl_ff[CRD_CTRL_STEP +: 3];
  wire enRise = wrCtrl && ctrlNew[CRD_CTRL_EN] && !codeEn;

  // fetch pointer as software sees it
  wire [31:0] fetchPtr = base_ff + 32'(offset_ff);

  // read mux, unmapped addresses read zero
  logic [31:0] rdMux;
  always_comb
  begin
    case (avsAddress)
      CRD_OFS_GPIO_DIR: rdMux = {24'h0, gpioDir_ff};
      CRD_OFS_GPIO_VAL: rdMux = {24'h0, gpioSync2_ff};
      CRD_OFS_CTRL: rdMux = {21'h0, ctrl_ff};
      CRD_OFS_BASE: rdMux = base_ff;
      CRD_OFS_PTR: rdMux = fetchPtr;
      CRD_OFS_STS: rdMux = {30'h0, sts_ff};
      CRD_OFS_MASK: rdMux = {30'h0, mask_ff};
      CRD_OFS_GTIM: rdMux = {20'h0, trec_ff, 4'h0, tdur_ff};
      default: rdMux = 32'h0;
    endcase
  end

  // bus handshake: one wait cycle, answer on the next
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      avsWaitrequest_ff <= 1'b1;
      avsReaddata_ff <= 32'h0;
    end
    else
    begin
      avsWaitrequest_ff <= !avsTake;
      if (avsTake)
      begin
        avsReaddata_ff <= rdMux;
      end
    end
  end

  // software-written registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gpioDir_ff <= CRD_RST_GPIO;
      gpioVal_ff <= CRD_RST_GPIO;
      ctrl_ff <= CRD_RST_CTRL;
      base_ff <= 32'h0;
      tdur_ff <= CRD_RST_TDUR;
      trec_ff <= CRD_RST_TREC;
      mask_ff <= 2'h0;
    end
    else
    begin
      if (wrDir) gpioDir_ff <= wrMerged[7:0];
      if (wrVal) gpioVal_ff <= wrMerged[7:0];
      if (wrCtrl) ctrl_ff <= ctrlNew[10:0];
      if (wrBase)
      begin
        base_ff <= crdMerge(base_ff, avsWritedata, avsByteenable)
                   & 32'hFFFF_FFFC;
      end
      if (wrGtim)
      begin
        tdur_ff <= gtimNew[CRD_GTIM_DUR +: 4];
        trec_ff <= gtimNew[CRD_GTIM_REC +: 4];
      end
      if (wrMask) mask_ff <= wrMerged[1:0];
    end
  end

  // gpio pins: two-stage input sync, registered drive
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gpioSync1_ff <= 8'h00;
      gpioSync2_ff <= 8'h00;
      gpioOut_ff <= 8'h00;
      gpioOeN_ff <= 8'hFF;
    end
    else
    begin
      gpioSync1_ff <= gpioIn;
      gpioSync2_ff <= gpioSync1_ff;
      gpioOut_ff <= gpioVal_ff;
      gpioOeN_ff <= ~gpioDir_ff;
    end
  end

  // code FIFO and fetch decisions
  logic fifoWrReady;
  logic fifoRdValid;
  logic [31:0] fifoRdData;
  crd_gstate_e gState_ff;
  wire fifoRdReady = (gState_ff == CRD_G_IDLE);
  wire memAccept = memRead_ff && !memWaitrequest;
  wire fetchGo = codeEn && !memRead_ff && fifoWrReady;
  wire [CRD_OFS_W-1:0] sizeMask = crdMask(CRD_SIZE_LOG0 + 5'(sizeSel));
  wire [CRD_OFS_W-1:0] stepMask = crdMask(CRD_STEP_LOG0 + 5'(stepSel));
  wire [CRD_OFS_W-1:0] nxtOffset = (offset_ff + CRD_WORD_BYTES) & sizeMask;
  wire stepHit = memAccept && (nxtOffset & stepMask) == '0;
  wire wrapHit = memAccept && nxtOffset == '0;

  crd_code_fifo u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wrValid(memAccept),
    .wrReady(fifoWrReady),
    .wrData(memReaddata),
    .rdValid(fifoRdValid),
    .rdReady(fifoRdReady),
    .rdData(fifoRdData)
  );

  // memory read master: one word at a time, held until accepted
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      memRead_ff <= 1'b0;
      memAddress_ff <= 32'h0;
      offset_ff <= '0;
    end
    else
    begin
      if (fetchGo)
      begin
        memRead_ff <= 1'b1;
        memAddress_ff <= fetchPtr;
      end
      else if (memAccept)
      begin
        memRead_ff <= 1'b0;
      end
      // restart at base on enable, else advance cyclically
      if (enRise) offset_ff <= '0;
      else if (memAccept) offset_ff <= nxtOffset;
    end
  end

  // sticky events, set wins over write-one-clear
  wire [1:0] stsSet = {wrapHit, stepHit};
  wire [1:0] stsClr = wrSts ? wrMerged[1:0] : 2'h0;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sts_ff <= 2'h0;
      irq_ff <= 1'b0;
    end
    else
    begin
      sts_ff <= (sts_ff & ~stsClr) | stsSet;
      irq_ff <= |(sts_ff & mask_ff);
    end
  end

  // guest bus master
  logic [31:0] gWord_ff;  // word being sent, low byte first
  logic [1:0] gByte_ff;   // byte index within word
  logic [3:0] gCnt_ff;    // strobe phase counter
  logic [3:0] gCsN_ff;
  logic [2:0] gAdr_ff;
  logic [7:0] gDat_ff;
  logic gDatOeN_ff;
  logic gWrN_ff;
  wire [3:0] tdurEff = (tdur_ff == 4'h0) ? 4'h1 : tdur_ff;
  wire [3:0] trecEff = (trec_ff == 4'h0) ? 4'h1 : trec_ff;
  wire [3:0] csSel = ~(4'h1 << guestId);

  // sequence: setup one cycle, strobe tdur, recover trec, per byte
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gState_ff <= CRD_G_IDLE;
      gWord_ff <= 32'h0;
      gByte_ff <= 2'h0;
      gCnt_ff <= 4'h0;
      gCsN_ff <= 4'hF;
      gAdr_ff <= 3'h0;
      gDat_ff <= 8'h00;
      gDatOeN_ff <= 1'b1;
      gWrN_ff <= 1'b1;
    end
    else
    begin
      case (gState_ff)
        CRD_G_IDLE:
        begin
          if (fifoRdValid)
          begin
            gWord_ff <= fifoRdData;
            gByte_ff <= 2'h0;
            gCsN_ff <= csSel;
            gAdr_ff <= CRD_CODE_REG_IDX;
            gDat_ff <= fifoRdData[7:0];
            gDatOeN_ff <= 1'b0;
            gState_ff <= CRD_G_SETUP;
          end
        end
        CRD_G_SETUP:
        begin
          gWrN_ff <= 1'b0;
          gCnt_ff <= tdurEff - 4'h1;
          gState_ff <= CRD_G_STRB;
        end
        CRD_G_STRB:
        begin
          if (gCnt_ff == 4'h0)
          begin
            gWrN_ff <= 1'b1;
            gCnt_ff <= trecEff - 4'h1;
            gState_ff <= CRD_G_RECV;
          end
          else gCnt_ff <= gCnt_ff - 4'h1;
        end
        CRD_G_RECV:
        begin
          if (gCnt_ff != 4'h0) gCnt_ff <= gCnt_ff - 4'h1;
          else if (gByte_ff == 2'h3)
          begin
            gCsN_ff <= 4'hF;
            gDatOeN_ff <= 1'b1;
            gState_ff <= CRD_G_IDLE;
          end
          else
          begin
            gByte_ff <= gByte_ff + 2'h1;
            gWord_ff <= gWord_ff >> 8;
            gDat_ff <= gWord_ff[15:8];
            gState_ff <= CRD_G_SETUP;
          end
        end
        default: gState_ff <= CRD_G_IDLE;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign avsReaddata = avsReaddata_ff;
  assign avsWaitrequest = avsWaitrequest_ff;
  assign memAddress = memAddress_ff;
  assign memRead = memRead_ff;
  assign gCsN = gCsN_ff;
  assign gAdr = gAdr_ff;
  assign gDatOut = gDat_ff;
  assign gDatOeN = gDatOeN_ff;
  assign gWrN = gWrN_ff;
  assign gpioOut = gpioOut_ff;
  assign gpioOeN = gpioOeN_ff;
  assign irq = irq_ff;

  // helper: cycles the write strobe has been low
  logic [4:0] lowCnt;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst) lowCnt <= 5'h0;
    else if (!gWrN_ff) lowCnt <= lowCnt + 5'h1;
    else lowCnt <= 5'h0;
  end

  property p_gpio_dir;
    @(posedge ref_clk) disable iff (sys_rst)
    ##1 gpioOeN_ff == ~$past(gpioDir_ff);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("pin enable does not follow direction");

  property p_gpio_val;
    @(posedge ref_clk) disable iff (sys_rst)
    wrVal |=> ##1 gpioOut_ff == $past(wrMerged[7:0], 2);
  endproperty
  a_gpio_val: assert property (p_gpio_val)
    else $error("pin value does not follow register");

  property p_guest_cs;
    @(posedge ref_clk) disable iff (sys_rst)
    gState_ff == CRD_G_IDLE && fifoRdValid |=> gCsN_ff == $past(csSel)
      && gAdr_ff == CRD_CODE_REG_IDX;
  endproperty
  a_guest_cs: assert property (p_guest_cs)
    else $error("wrong guest select or address");

  property p_strobe_len;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(gWrN_ff) |-> lowCnt == 5'(tdurEff);
  endproperty
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe low time wrong");

  property p_fetch_en;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(memRead_ff) |-> $past(codeEn) && $past(fifoWrReady);
  endproperty
  a_fetch_en: assert property (p_fetch_en)
    else $error("fetch started while disabled or full");

  property p_wrap;
    @(posedge ref_clk) disable iff (sys_rst)
    memAccept && !enRise && offset_ff == sizeMask - 20'h3
      |=> offset_ff == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("pointer did not wrap to base");

  sequence s_step;
    stepHit;
  endsequence
  property p_step_irq;
    @(posedge ref_clk) disable iff (sys_rst)
    s_step ##0 mask_ff[CRD_STS_STEP] |=> sts_ff[CRD_STS_STEP] ##1 irq_ff;
  endproperty
  a_step_irq: assert property (p_step_irq)
    else $error("report step gave no interrupt");

  property p_ptr_read;
    @(posedge ref_clk) disable iff (sys_rst)
    avsTake && avsAddress == CRD_OFS_PTR |=> avsReaddata_ff == $past(fetchPtr);
  endproperty
  a_ptr_read: assert property (p_ptr_read)
    else $error("pointer read wrong");

  property p_feed;
    @(posedge ref_clk) disable iff (sys_rst)
    gState_ff == CRD_G_IDLE && fifoRdValid |=> ##1 !gWrN_ff;
  endproperty
  a_feed: assert property (p_feed)
    else $error("fifo data not written to guest");

endmodule

// [design/crd_pkg.sv]
// crd_pkg: register map, field positions, reset values and states of the
// code-read DMA with guest port feed.
// assumes: 32-bit Avalon-MM register slave, byte addresses, 20 MHz clock.
package crd_pkg;

  // register byte offsets
  localparam logic [7:0] CRD_OFS_GPIO_DIR = 8'h00; // 1 = pin is output
  localparam logic [7:0] CRD_OFS_GPIO_VAL = 8'h04; // out value / pin read
  localparam logic [7:0] CRD_OFS_CTRL = 8'h08;     // enable, guest, sizes
  localparam logic [7:0] CRD_OFS_BASE = 8'h0C;     // code buffer base
  localparam logic [7:0] CRD_OFS_PTR = 8'h10;      // fetch pointer, RO
  localparam logic [7:0] CRD_OFS_STS = 8'h14;      // sticky events, W1C
  localparam logic [7:0] CRD_OFS_MASK = 8'h18;     // event mask
  localparam logic [7:0] CRD_OFS_GTIM = 8'h30;     // guest port timing

  // control register fields
  localparam int CRD_CTRL_EN = 0;      // code-read enable
  localparam int CRD_CTRL_GID = 1;     // guest id, 2 bits
  localparam int CRD_CTRL_SIZE = 4;    // buffer size select, 3 bits
  localparam int CRD_CTRL_STEP = 8;    // report step select, 3 bits
  // timing register fields
  localparam int CRD_GTIM_DUR = 0;     // strobe duration, 4 bits
  localparam int CRD_GTIM_REC = 8;     // strobe recovery, 4 bits
  // status / mask bits
  localparam int CRD_STS_STEP = 0;     // report step passed
  localparam int CRD_STS_WRAP = 1;     // buffer wrapped

  // reset values
  localparam logic [7:0] CRD_RST_GPIO = 8'h00;
  localparam logic [10:0] CRD_RST_CTRL = 11'h000;
  localparam logic [3:0] CRD_RST_TDUR = 4'hF;
  localparam logic [3:0] CRD_RST_TREC = 4'hF;

  // sizes: buffer is 4 KB << sel, report step is 256 B << sel
  localparam logic [4:0] CRD_SIZE_LOG0 = 5'h0C;
  localparam logic [4:0] CRD_STEP_LOG0 = 5'h08;
  localparam int CRD_OFS_W = 20;       // byte offset width in buffer
  localparam logic [19:0] CRD_WORD_BYTES = 20'h00004;

  // guest window: eight 8-bit locations per guest, code register index
  localparam int CRD_GUESTS = 4;
  localparam logic [2:0] CRD_CODE_REG_IDX = 3'h0;

  // code FIFO geometry
  localparam int CRD_FIFO_W = 32;
  localparam int CRD_FIFO_D = 8;

  // guest bus master states, one-hot
  typedef enum logic [3:0] {
    CRD_G_IDLE = 4'b0001,
    CRD_G_SETUP = 4'b0010,
    CRD_G_STRB = 4'b0100,
    CRD_G_RECV = 4'b1000
  } crd_gstate_e;

endpackage

// [verif/crd_far_model.sv]
// crd_far_model: system memory that answers code fetches, and a guest
// decoder that logs every byte strobed to it.
// assumes: bench drives memStall; bytes are logged as {cs, adr, data}.
`timescale 1ns/1ps
module crd_far_model
  import crd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic memStall,
  input wire logic [31:0] memAddress,
  input wire logic memRead,
  output logic [31:0] memReaddata,
  output logic memWaitrequest,
  input wire logic [3:0] gCsN,
  input wire logic [2:0] gAdr,
  input wire logic [7:0] gDatOut,
  input wire logic gDatOeN,
  input wire logic gWrN
);
  logic [14:0] gotQ[$]; // bytes seen by the guest
  logic prevWrN = 1'b1; // strobe level one edge ago

  // buffer content is a fixed pattern of its address
  function automatic logic [31:0] mdata(input logic [31:0] a);
    return {a[15:0] ^ 16'hC35A, a[15:0]};
  endfunction

  // stalls come from the bench; stalled data is inverted
  assign memWaitrequest = memStall;
  assign memReaddata = memStall ? ~mdata(memAddress) : mdata(memAddress);

  // decoder latches a byte when the write strobe ends
  always @(posedge ref_clk)
  begin
    prevWrN <= gWrN;
    if (prevWrN === 1'b0 && gWrN === 1'b1 && gDatOeN === 1'b0)
      gotQ.push_back({gCsN, gAdr, gDatOut});
  end
endmodule

// [verif/testbench.sv]
// testbench: registers, GPIO, code fetch runs for every guest id.
// assumes: crd_far_model serves memory and logs guest bytes.
`timescale 1ns/1ps
module testbench
  import crd_pkg::*;
;
  logic ref_clk = 1'b0; // 20 MHz
  logic sys_rst = 1'b1; // async, active high
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata, memAddress, memReaddata;
  logic avsWaitrequest, memRead, memWaitrequest, gDatOeN, gWrN, irq;
  logic memStall = 1'b0; // random memory wait states
  logic [3:0] gCsN;
  logic [2:0] gAdr;
  logic [7:0] gDatOut, gpioOut, gpioOeN;
  logic [7:0] gpioIn = 8'h00; // random pin levels
  int err_total = 0;
  int cmp_count = 0;

  always #25 ref_clk = ~ref_clk;

  // memory stalls about one cycle in four
  always @(posedge ref_clk)
    memStall <= ($urandom_range(3) == 0);

  crd_code_read_dma uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsByteenable(4'hF),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .memAddress(memAddress), .memRead(memRead),
    .memReaddata(memReaddata), .memWaitrequest(memWaitrequest),
    .gCsN(gCsN), .gAdr(gAdr), .gDatOut(gDatOut), .gDatOeN(gDatOeN),
    .gWrN(gWrN), .gpioIn(gpioIn), .gpioOut(gpioOut),
    .gpioOeN(gpioOeN), .irq(irq));

  crd_far_model mdl (.ref_clk(ref_clk), .memStall(memStall),
    .memAddress(memAddress), .memRead(memRead),
    .memReaddata(memReaddata), .memWaitrequest(memWaitrequest),
    .gCsN(gCsN), .gAdr(gAdr), .gDatOut(gDatOut), .gDatOeN(gDatOeN),
    .gWrN(gWrN));

  // expected buffer content, same pattern the memory holds
  function automatic logic [31:0] mdata(input logic [31:0] a);
    return {a[15:0] ^ 16'hC35A, a[15:0]};
  endfunction

  // verdict and end of run
  task automatic tally_and_finish();
    if (err_total == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a bound that ran out ends the run
  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // one Avalon-MM access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= ~w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avsWaitrequest !== 1'b0 && n < 20);
    tmo(n, 20);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge ref_clk);
  endtask

  // main sequence
  initial
  begin
    logic [31:0] q, base, e;
    logic [7:0] dir, val;
    int n, k, words;
    void'($urandom(7992));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // reset state: pins are inputs, guest bus idle
    chk(32'(gpioOeN), 32'h0000_00FF);
    chk(32'({gCsN, irq, memRead}), 32'h0000_003C);
    bus(1'b0, CRD_OFS_GTIM, 32'h0, q);
    chk(q, 32'h0000_0F0F);
    bus(1'b0, CRD_OFS_CTRL, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0); // unmapped place reads zero
    // pins as outputs follow their value bits
    dir = 8'($urandom);
    val = 8'($urandom);
    gpioIn <= 8'($urandom);
    bus(1'b1, CRD_OFS_GPIO_DIR, 32'(dir), q);
    bus(1'b1, CRD_OFS_GPIO_VAL, 32'(val), q);
    // pin drive lags the value register by one edge
    @(posedge ref_clk);
    chk(32'(gpioOeN), {24'h0, ~dir});
    chk(32'(gpioOut & dir), 32'(val & dir));
    bus(1'b0, CRD_OFS_GPIO_VAL, 32'h0, q);
    chk(q & 32'hFF, 32'(gpioIn));
    // short strobes, random base; set up before enabling
    bus(1'b1, CRD_OFS_GTIM, 32'h0000_0102, q);
    bus(1'b0, CRD_OFS_GTIM, 32'h0, q);
    chk(q, 32'h0000_0102);
    base = $urandom & 32'h0FFF_FFFC;
    bus(1'b1, CRD_OFS_BASE, base, q);
    bus(1'b0, CRD_OFS_BASE, 32'h0, q);
    chk(q, base);
    bus(1'b1, CRD_OFS_MASK, 32'h0, q);
    // one run per guest id; the last one wraps the 4 KB buffer
    for (int g = 0; g < 4; g++)
    begin
      words = (g == 3) ? 1030 : 70;
      mdl.gotQ.delete();
      // run 1 has the step event unmasked while fetching
      bus(1'b1, CRD_OFS_MASK, 32'(g == 1), q);
      bus(1'b1, CRD_OFS_CTRL, 32'(g * 2 + 1), q);
      n = 0;
      while (mdl.gotQ.size() < 4 * words && n < 40000)
      begin
        @(posedge ref_clk);
        n++;
      end
      tmo(n, 40000);
      bus(1'b1, CRD_OFS_CTRL, 32'(g * 2), q);
      // wait for the drain and a quiet memory port
      n = 0;
      k = 0;
      while (k < 64 && n < 2000)
      begin
        @(posedge ref_clk);
        n++;
        k = (gCsN === 4'hF && memRead === 1'b0) ? k + 1 : 0;
      end
      chk(32'(k), 32'd64);
      // every byte in order, to the chosen guest, nothing lost
      for (int j = 0; j < mdl.gotQ.size(); j++)
      begin
        e = mdata(base + 32'(4 * ((j / 4) % 1024))) >> (8 * (j % 4));
        e = {17'h0, ~(4'h1 << g), 3'h0, e[7:0]};
        chk(32'(mdl.gotQ[j]), e);
      end
      words = mdl.gotQ.size() / 4;
      chk(32'(mdl.gotQ.size() % 4), 32'h0);
      bus(1'b0, CRD_OFS_PTR, 32'h0, q);
      chk(q, base + 32'((4 * words) % 4096));
      bus(1'b0, CRD_OFS_STS, 32'h0, q);
      chk(q & 32'h3, {30'h0, words >= 1024, 1'b1});
      chk(32'(irq), 32'(g == 1)); // masked runs stay quiet
      bus(1'b1, CRD_OFS_MASK, 32'h3, q);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h1);
      bus(1'b1, CRD_OFS_STS, 32'h3, q);
      repeat (2) @(posedge ref_clk);
      chk(32'(irq), 32'h0); // cleared by writing ones
      bus(1'b1, CRD_OFS_MASK, 32'h0, q);
    end
    tally_and_finish();
  end
endmodule
